// ### rtl/dram1k_host_map.svh
// constants for the 1k x 1 dynamic ram access-cycle controller
// assumes a 4 ns controller clock; counts round as the timing demands
`ifndef DRAM1K_HOST_MAP_SVH
`define DRAM1K_HOST_MAP_SVH

`define D1K_CLK_NS       4
`define D1K_ADDR_W       10
`define D1K_ROW_W        5
`define D1K_ROWS         32
// least times in ns
`define D1K_T_PRE_NS     125
`define D1K_T_ACC_NS     300
`define D1K_T_WP_NS      50
`define D1K_T_CYC_NS     580
// longest time in ns for one full refresh pass
`define D1K_T_REF_NS     2000000
// least times round up to whole cycles
`define D1K_T_PRE_CYC    ((`D1K_T_PRE_NS + `D1K_CLK_NS - 1) / `D1K_CLK_NS)
`define D1K_T_ACC_CYC    ((`D1K_T_ACC_NS + `D1K_CLK_NS - 1) / `D1K_CLK_NS)
`define D1K_T_WP_CYC     ((`D1K_T_WP_NS + `D1K_CLK_NS - 1) / `D1K_CLK_NS)
`define D1K_T_CYC_CYC    ((`D1K_T_CYC_NS + `D1K_CLK_NS - 1) / `D1K_CLK_NS)
// per-row spacing rounds down, with two access cycles of slack for arbitration
`define D1K_REF_INT_CYC  ((`D1K_T_REF_NS / `D1K_ROWS - 2 * `D1K_T_CYC_NS) / `D1K_CLK_NS)

`endif

// ### rtl/dram1k_pkg.sv
// types shared by the 1k x 1 dynamic ram controller
// assumes dram1k_host_map.svh supplies the widths
`include "dram1k_host_map.svh"

package dram1k_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE,
    ST_ACC,
    ST_WP,
    ST_REC
  } dram1k_state_t;

  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic                   rmw;
    logic [`D1K_ADDR_W-1:0] addr;
    logic                   wdata;
  } dram1k_req_t;

  typedef struct packed {
    logic valid;
    logic rdata;
  } dram1k_rsp_t;

endpackage : dram1k_pkg

// ### rtl/dram1k_host.sv
// controller that runs read, write, read-modify-write and refresh cycles
// on a 1k x 1 dynamic ram; dram output is synchronous to CLK here
//
// What this block does
// - writes pulse read/write low with data held stable at the address.
// - read-modify-write returns read data before the write pulse, same cycle.
// - refresh is a read cycle stepping through all five low address bits.
// - every refresh row is visited within the two millisecond refresh period.
`timescale 1ns/1ps

module dram1k_host
  import dram1k_pkg::*;
#(
  parameter int REF_INTERVAL = `D1K_REF_INT_CYC
) (
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RESET_N,
  // user request and answer
  input  wire dram1k_req_t            REQ,
  output logic                        REQ_READY,
  output dram1k_rsp_t                 RSP,
  output logic                        REFRESH_BUSY,
  // dram pins
  output logic [`D1K_ADDR_W-1:0]      DRAM_ADDR,
  output logic                        DRAM_RW,
  output logic                        DRAM_PRE,
  output logic                        DRAM_CE,
  output logic                        DRAM_DIN,
  input  wire logic                   DRAM_DOUT
);

  localparam int PRE_C = `D1K_T_PRE_CYC;
  localparam int ACC_C = `D1K_T_ACC_CYC;
  localparam int WP_C  = `D1K_T_WP_CYC;
  localparam int CYC_C = `D1K_T_CYC_CYC;

  if (REF_INTERVAL < 2 * CYC_C || REF_INTERVAL > 65000) begin : g_chk
    $error("REF_INTERVAL must fit two access cycles and the 16-bit tick counter");
  end

  // ==========================================================
  // phase timing
  // ==========================================================
  function automatic logic [7:0] phase_len(dram1k_state_t st, logic wr);
    logic [7:0] len;
    len = 8'h01;
    case (st)
      ST_PRE:  len = 8'(PRE_C);
      ST_ACC:  len = 8'(ACC_C);
      ST_WP:   len = 8'(WP_C);
      ST_REC:  len = wr ? 8'(CYC_C - PRE_C - ACC_C - WP_C) : 8'(CYC_C - PRE_C - ACC_C);
      default: len = 8'h01;
    endcase
    return len;
  endfunction : phase_len

  dram1k_state_t          state_r;
  dram1k_state_t          state_nxt;
  logic [7:0]             cnt_r;
  logic                   is_ref_r;
  logic                   wr_r;
  logic                   rmw_r;
  logic [`D1K_ROW_W-1:0]  row_r;
  logic [15:0]            tick_r;
  logic                   ref_pend_r;
  logic                   ref_pend_nxt;
  logic                   take_req;
  logic                   take_ref;
  logic                   phase_end;
  logic                   tick_hit;
  logic                   rsp_sent_r;

  assign phase_end = (state_r != ST_IDLE) && (cnt_r == phase_len(state_r, wr_r) - 8'h01);
  assign take_req  = (state_r == ST_IDLE) && REQ.valid && REQ_READY;
  assign take_ref  = (state_r == ST_IDLE) && ref_pend_r && !take_req;
  assign tick_hit  = (tick_r == 16'(REF_INTERVAL - 1));

  // ==========================================================
  // refresh pacing
  // ==========================================================
  // evenly spaced ticks
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tick_r <= 16'h0000;
    end else if (tick_hit) begin
      tick_r <= 16'h0000;
    end else begin
      tick_r <= tick_r + 16'h0001;
    end
  end

  // set wins over the clear when both land together
  always_comb begin
    ref_pend_nxt = ref_pend_r;
    if (take_ref) begin
      ref_pend_nxt = 1'b0;
    end
    if (tick_hit) begin
      ref_pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ref_pend_r <= 1'b0;
    end else begin
      ref_pend_r <= ref_pend_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      row_r <= 5'h00;
    end else if (take_ref) begin
      row_r <= row_r + 5'h01;
    end
  end

  // ==========================================================
  // cycle sequencer
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take_req || take_ref) begin
          state_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        if (phase_end) begin
          state_nxt = ST_ACC;
        end
      end
      ST_ACC: begin
        if (phase_end) begin
          state_nxt = wr_r ? ST_WP : ST_REC;
        end
      end
      ST_WP: begin
        if (phase_end) begin
          state_nxt = ST_REC;
        end
      end
      ST_REC: begin
        if (phase_end) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= ST_IDLE;
      cnt_r   <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r) ? 8'h00 : cnt_r + 8'h01;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      is_ref_r <= 1'b0;
      wr_r     <= 1'b0;
      rmw_r    <= 1'b0;
    end else if (take_req) begin
      is_ref_r <= 1'b0;
      wr_r     <= REQ.write | REQ.rmw;
      rmw_r    <= REQ.rmw;
    end else if (take_ref) begin
      is_ref_r <= 1'b1;
      wr_r     <= 1'b0;
      rmw_r    <= 1'b0;
    end
  end

  // ==========================================================
  // dram pins, all registered
  // ==========================================================
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DRAM_ADDR <= 10'h000;
      DRAM_DIN  <= 1'b0;
    end else if (take_req) begin
      DRAM_ADDR <= REQ.addr;
      DRAM_DIN  <= REQ.wdata;
    end else if (take_ref) begin
      DRAM_ADDR <= {5'h00, row_r};
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DRAM_PRE <= 1'b0;
      DRAM_CE  <= 1'b1;
      DRAM_RW  <= 1'b1;
    end else begin
      DRAM_PRE <= (state_nxt == ST_PRE);
      DRAM_CE  <= !((state_nxt == ST_ACC) || (state_nxt == ST_WP));
      DRAM_RW  <= (state_nxt != ST_WP);
    end
  end

  // ==========================================================
  // answers
  // ==========================================================
  // capture read data at end of access
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RSP        <= '0;
      rsp_sent_r <= 1'b0;
    end else begin
      RSP.valid <= 1'b0;
      if (state_r == ST_ACC && phase_end && !is_ref_r && (!wr_r || rmw_r)) begin
        RSP.valid  <= 1'b1;
        RSP.rdata  <= DRAM_DOUT;
        rsp_sent_r <= 1'b1;
      end else if (state_r == ST_IDLE) begin
        rsp_sent_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REQ_READY    <= 1'b0;
      REFRESH_BUSY <= 1'b0;
    end else begin
      REQ_READY    <= (state_nxt == ST_IDLE) && !ref_pend_nxt && !take_req && !take_ref;
      REFRESH_BUSY <= take_ref || (is_ref_r && state_nxt != ST_IDLE);
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  logic [7:0]  wp_len_r;
  logic [15:0] gap_r;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wp_len_r <= 8'h00;
      gap_r    <= 16'h0000;
    end else begin
      wp_len_r <= DRAM_RW ? 8'h00 : wp_len_r + 8'h01;
      gap_r    <= take_ref ? 16'h0000 : gap_r + 16'h0001;
    end
  end

  write_pulse_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(DRAM_RW) |-> wp_len_r == 8'(WP_C))
    else $error("write pulse width wrong");

  write_data_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (!DRAM_RW && !$fell(DRAM_RW)) |-> ($stable(DRAM_DIN) && $stable(DRAM_ADDR) && !DRAM_CE))
    else $error("data or address moved during write pulse");

  rmw_order_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    ($fell(DRAM_RW) && rmw_r) |-> rsp_sent_r)
    else $error("rmw write before read answer");

  row_step_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    take_ref |=> (row_r == $past(row_r) + 5'h01) && DRAM_ADDR[9:5] == 5'h00 && DRAM_RW)
    else $error("refresh row did not step");

  ref_gap_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    gap_r <= 16'(REF_INTERVAL + 2 * CYC_C))
    else $error("refresh gap too long");

  ref_prio_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (state_r == ST_IDLE && ref_pend_r && !REQ_READY) |=> (state_r == ST_PRE && is_ref_r))
    else $error("pending refresh not started");

endmodule : dram1k_host

// ### test/dram1k_ram_model.sv
// behavioural 1k x 1 dynamic ram driven through its pins
// assumes pins change just after the rising clk edge; clk only times the model
`timescale 1ns/1ps

module dram1k_ram_model #(
  parameter int AGE_LIMIT = 12000
) (
  // timing
  input  wire logic       clk,
  // ram pins
  input  wire logic [9:0] addr,
  input  wire logic       rw,
  input  wire logic       pre,
  input  wire logic       ce,
  input  wire logic       din,
  output logic            dout,
  // set when some row went too long without a read
  output logic            lost
);
  logic mem [1024];
  logic last_r;
  int   age [32];

  initial begin
    lost = 1'h0;
    last_r = 1'h0;
    foreach (mem[i]) mem[i] = 1'h0;
    foreach (age[i]) age[i] = 0;
  end

  // ====================
  // data path
  // selected read, deselected output drives the inverse of the last read value
  assign dout = ce ? ~last_r : mem[addr];

  always @(posedge clk) begin
    if (!ce) begin
      last_r <= dout;
    end
  end

  always @(posedge clk) begin
    if (!ce && !rw && !pre) begin
      mem[addr] <= din;
    end
  end

  // ====================
  // retention
  // row read restores charge
  always @(posedge clk) begin
    foreach (age[i]) begin
      age[i] <= age[i] + 1;
      if (age[i] > AGE_LIMIT) begin
        lost <= 1'h1;
      end
    end
    if (!ce && rw && !pre) begin
      age[addr[4:0]] <= 0;
    end
  end
endmodule : dram1k_ram_model

// ### test/dram_1k_access_cycles_bench.sv
// self-checking bench for the 1k x 1 dram access-cycle controller
// assumes the design files and the ram model are compiled first
`timescale 1ns/1ps
`include "dram1k_host_map.svh"

module dram_1k_access_cycles_bench
  import dram1k_pkg::*;
;
  logic                   CLK;
  logic                   RESET_N;
  dram1k_req_t            req;
  logic                   ready;
  dram1k_rsp_t            rsp;
  logic                   busy;
  logic                   busy_q;
  logic [`D1K_ADDR_W-1:0] addr;
  logic                   rw;
  logic                   pre;
  logic                   ce;
  logic                   din;
  logic                   dout;
  logic                   lost;
  int                     err_count;
  int                     cmp_count;
  int                     ref_seen;
  int                     hi_bad;
  logic [13:0]            tab [8];

  // ====================
  // design and ram
  dram1k_host #(.REF_INTERVAL(300)) dut (
    .CLK(CLK), .RESET_N(RESET_N), .REQ(req), .REQ_READY(ready), .RSP(rsp),
    .REFRESH_BUSY(busy), .DRAM_ADDR(addr), .DRAM_RW(rw), .DRAM_PRE(pre),
    .DRAM_CE(ce), .DRAM_DIN(din), .DRAM_DOUT(dout)
  );
  dram1k_ram_model #(.AGE_LIMIT(12000)) ram (
    .clk(CLK), .addr(addr), .rw(rw), .pre(pre), .ce(ce), .din(din),
    .dout(dout), .lost(lost)
  );

  initial begin
    CLK = 1'h0;
    forever #2 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    busy_q <= busy;
    if (busy && !busy_q) ref_seen++;
  end

  always @(negedge CLK) begin
    if (busy && !ce && addr[9:5] !== 5'h00) hi_bad++;
  end

  // ====================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic take(input logic [13:0] op);
    int n;
    n = 0;
    req = '{1'h1, op[13], op[12], op[11:2], op[1]};
    do begin
      @(negedge CLK);
      n++;
    end while (ready !== 1'h1 && n < 2000);
    chk({15'h0000, ready}, 16'h0001, "ready");
    @(posedge CLK);
    #1 req.valid = 1'h0;
  endtask : take

  // waits for the cycle to end; reads must answer 108 edges after taking
  task automatic settle(input logic [13:0] op);
    int   n;
    int   hit;
    logic got;
    n = 0;
    hit = 0;
    got = 1'h0;
    do begin
      @(negedge CLK);
      n++;
      if (rsp.valid === 1'h1) begin
        hit = n;
        got = rsp.rdata;
      end
    end while (ready !== 1'h1 && n < 400);
    if (!op[13] || op[12]) begin
      chk(16'(hit), 16'h006C, "latency");
      chk({15'h0000, got}, {15'h0000, op[0]}, "rdata");
    end else begin
      chk(16'(hit), 16'h0000, "write rsp");
    end
    @(posedge CLK);
    #1;
  endtask : settle

  task automatic finish_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // ====================
  // tests
  initial begin
    tab[0] = {2'h2, 10'h3FF, 2'h2};
    tab[1] = {2'h2, 10'h000, 2'h0};
    tab[2] = {2'h0, 10'h3FF, 2'h1};
    tab[3] = {2'h0, 10'h000, 2'h0};
    tab[4] = {2'h1, 10'h155, 2'h2};
    tab[5] = {2'h0, 10'h155, 2'h1};
    tab[6] = {2'h1, 10'h155, 2'h1};
    tab[7] = {2'h0, 10'h155, 2'h0};
  end

  initial begin
    #120000;
    err_count++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    RESET_N = 1'h0;
    req = '0;
    repeat (6) @(posedge CLK);
    chk({10'h000, ce, rw, pre, ready, rsp.valid, busy}, 16'h0030, "reset");
    repeat (6) @(posedge CLK);
    #1 RESET_N = 1'h1;
    repeat (2) @(posedge CLK);
    #1;
    for (int i = 0; i < 8; i++) begin
      take(tab[i]);
      settle(tab[i]);
    end
    $display("test table done");
    // reset in the access phase must drop the write
    take({2'h2, 10'h0AA, 2'h2});
    repeat (40) @(posedge CLK);
    #1 RESET_N = 1'h0;
    #1;
    chk({13'h0000, ce, rw, ready}, 16'h0006, "abort");
    repeat (12) @(posedge CLK);
    #1 RESET_N = 1'h1;
    repeat (2) @(posedge CLK);
    #1;
    take({2'h0, 10'h0AA, 2'h0});
    settle({2'h0, 10'h0AA, 2'h0});
    $display("test abort done");
    repeat (13000) @(posedge CLK);
    #1;
    chk({15'h0000, lost}, 16'h0000, "lost");
    chk(16'(hi_bad), 16'h0000, "row bits");
    chk(16'(ref_seen > 31), 16'h0001, "refresh");
    // look at the ram select only between cycles, not inside a refresh
    do begin
      @(negedge CLK);
    end while (ready !== 1'h1);
    chk({15'h0000, ce}, 16'h0001, "idle ce");
    $display("test refresh done");
    finish_test();
  end
endmodule : dram_1k_access_cycles_bench
